// file: verilog/cfh_core.sv
// Purpose: CAN receive object filter with serial host link
// Assumes: CAN engine strobes run on ref_clk; host waits for handshake
// Notes: one ref_clk per instruction cycle; up to eight objects
`timescale 1ns/10ps
// How it works
// - Host link moves commands and data as 8-bit packets.
// - Every eighth shift clock raises a link request pulse.
// - Handshake line inverts once a received byte has been taken.
// - First byte of a packet is a command and sets the request flag.
// - Idle tick every 4096 cycles, or selectable 4k to 32k.
// - Optional 16-bit auto-reload timer drives the tick and timed events.
// - Separate receive, transmit and error CAN event pulses.
// - Message-complete pulse only for a whole error-free frame.
// - System time is captured and stored with accepted messages.
// - Each object compares identifier and control bytes, stores on match, then tries next.
// - Accepting object sets its bit in the received-status byte.
// - Unread object accepting again sets its overrun bit first.
// - Objects take 10 bytes, or 12 with a time stamp.
// - Each object's acceptance finishes within 19 instruction cycles.
// - Data length from low control nibble; zero copies no data.
// - One receive byte is taken in every cycle its full flag is high, up to 10 bytes per frame.
module cfh_core import cfh_pkg::*; #(
  parameter int NOBJ = CFH_MAX_OBJ,
  parameter bit TSTAMP = 1'b1,
  parameter int IDLE_BASE = CFH_IDLE_BASE_CYC
) (
  input logic ref_clk, // Core clock
  input logic rst_b, // Async reset, active low
  input logic serial_shift_clock, // Link clock from host
  input logic link_sdi, // Serial data in
  output logic link_sdo, // Serial data out
  input logic link_sel_b, // Host selects link, low
  output logic link_hs, // Handshake line level
  output logic [7:0] host_byte, // Byte from host
  output logic host_byte_cmd, // Byte is a command
  output logic host_byte_valid, // Byte waiting
  input logic host_byte_ready, // User takes byte
  input logic [7:0] reply_byte, // Next byte for host
  output logic comm_req_flag, // Command arrived, sticky
  input logic comm_req_clr, // Clears request flag
  output logic link_req_irq, // Pulse per whole byte
  input logic [1:0] tick_src, // Tick source select
  input logic [1:0] idle_div_sel, // 4k, 8k, 16k, 32k
  input logic [15:0] reload_value, // Reload timer period-1
  input logic auto_tx_en, // Enable timed transmit
  output logic tick_pulse, // System time tick
  output logic [15:0] sys_time, // System time
  output logic auto_tx_req, // Timed transmit trigger
  input logic [7:0] can_byte, // Receive buffer byte
  input logic rx_buffer_full_flag, // Receive byte valid
  input logic can_frame_end, // Frame finished
  input logic can_frame_err, // Frame had an error
  input logic can_tx_done, // Transmit finished
  input logic can_err_evt, // Bus error seen
  output logic can_rx_irq, // Receive event pulse
  output logic can_tx_irq, // Transmit event pulse
  output logic can_err_irq, // Error event pulse
  output logic msg_complete, // Good frame pulse
  input logic [NOBJ*16-1:0] acc_id, // Acceptance ids
  output logic [NOBJ-1:0] rx_status, // New data per object
  output logic [NOBJ-1:0] rx_overwrite, // Overrun per object
  input logic [NOBJ-1:0] obj_read_ack, // Host read object
  input logic [NOBJ-1:0] ovr_clr, // Clears overrun bits
  input logic [2:0] rd_obj, // Object to read
  input logic [3:0] rd_idx, // Byte within object
  output logic [7:0] rd_data, // Object byte
  output logic scan_busy // Filter scan running
);
  localparam int STRIDE = TSTAMP ? CFH_OBJ_BYTES_TS : CFH_OBJ_BYTES;
  localparam int MEMB = NOBJ * STRIDE;
  localparam int OW = (NOBJ > 1) ? $clog2(NOBJ) : 1;
  localparam int MW = $clog2(MEMB + 1);

  typedef struct packed {
    logic [1:0] sel_sy;
    logic [2:0] tg_sy;
    logic first_pend;
    logic hs;
    logic [7:0] tx;
    logic comm_req;
    logic link_irq;
    logic [16:0] tcnt;
    logic tick;
    logic [15:0] stime;
    logic auto_tx;
    logic [CFH_FRAME_BYTES-1:0][7:0] fb;
    logic [3:0] bcnt;
    logic [CFH_FRAME_BYTES-1:0][7:0] sb;
    logic [15:0] ts;
    logic rx_irq;
    logic tx_irq;
    logic err_irq;
    logic msg_done;
    cfh_scan_e st;
    logic [OW-1:0] obj;
    logic [3:0] cnt;
    logic [3:0] dlc;
    logic [NOBJ-1:0] rxs;
    logic [NOBJ-1:0] ovr;
    logic [MEMB-1:0][7:0] mem;
    logic [7:0] rd;
  } cfh_core_s;

  cfh_core_s q, d;
  logic [7:0] link_rx;
  logic link_tgl;
  logic [8:0] fifo_out;
  logic fifo_in_ready;
  logic byte_evt;
  logic [16:0] limit;
  logic [MW-1:0] base;
  logic [3:0] dlc_raw;

  // ==========================================================
  // Link domain and byte buffer
  cfh_link u_link (
    .serial_shift_clock(serial_shift_clock),
    .rst_b(rst_b),
    .sdi(link_sdi),
    .sdo(link_sdo),
    .tx_byte(q.tx),
    .rx_byte(link_rx),
    .rx_tgl(link_tgl)
  );

  // Toggle edge seen only between second and third stage
  assign byte_evt = q.tg_sy[1] ^ q.tg_sy[2];

  // Rx byte is stable until the host sees the handshake invert
  cfh_fifo #(.W(9), .DEPTH(CFH_BUF_DEPTH)) u_buf (
    .clk(ref_clk),
    .rst_b(rst_b),
    .in_data({q.first_pend, link_rx}),
    .in_valid(byte_evt),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(host_byte_valid),
    .out_ready(host_byte_ready)
  );

  assign host_byte = fifo_out[7:0];
  assign host_byte_cmd = fifo_out[8];
  assign link_hs = q.hs;
  assign comm_req_flag = q.comm_req;
  assign link_req_irq = q.link_irq;
  assign tick_pulse = q.tick;
  assign sys_time = q.stime;
  assign auto_tx_req = q.auto_tx;
  assign can_rx_irq = q.rx_irq;
  assign can_tx_irq = q.tx_irq;
  assign can_err_irq = q.err_irq;
  assign msg_complete = q.msg_done;
  assign rx_status = q.rxs;
  assign rx_overwrite = q.ovr;
  assign rd_data = q.rd;
  assign scan_busy = (q.st != CFH_SCAN_IDLE);

  // ==========================================================
  // Tick period for the chosen source
  always_comb begin
    case (tick_src)
      CFH_TICK_IDLE_SEL: limit = 17'(IDLE_BASE << idle_div_sel) - 17'h1;
      CFH_TICK_RELOAD: limit = {1'b0, reload_value};
      default: limit = 17'(IDLE_BASE) - 17'h1;
    endcase
  end

  // Object base address and masked data length nibble
  assign base = MW'(q.obj * STRIDE);
  assign dlc_raw = 4'(q.sb[CFH_OFS_CTRL] & CFH_DLC_MASK);

  // ==========================================================
  // Next state for link control, timer, frame and scan
  always_comb begin
    d = q;
    d.sel_sy = {q.sel_sy[0], link_sel_b};
    d.tg_sy = {q.tg_sy[1:0], link_tgl};
    d.link_irq = byte_evt;
    d.tick = 1'b0;
    d.auto_tx = 1'b0;
    d.rx_irq = rx_buffer_full_flag;
    d.tx_irq = can_tx_done;
    d.err_irq = can_err_evt;
    d.msg_done = 1'b0;

    // Packet framing: deselect re-arms the command slot
    if (q.sel_sy[1]) begin
      d.first_pend = 1'b1;
    end
    if (byte_evt && fifo_in_ready) begin
      d.first_pend = 1'b0;
    end
    // Request flag; a new command beats a same-cycle clear
    if (comm_req_clr) begin
      d.comm_req = 1'b0;
    end
    if (byte_evt && fifo_in_ready && q.first_pend) begin
      d.comm_req = 1'b1;
    end
    // Taking a byte frees the host for the next one
    if (host_byte_valid && host_byte_ready) begin
      d.hs = !q.hs;
      d.tx = reply_byte;
    end

    // System time tick
    if (q.tcnt >= limit) begin
      d.tcnt = 17'h0;
      d.tick = 1'b1;
      d.stime = q.stime + 16'h1;
      d.auto_tx = auto_tx_en;
    end else begin
      d.tcnt = q.tcnt + 17'h1;
    end

    // Receive buffer bytes, taken in the cycle they arrive
    if (rx_buffer_full_flag && q.bcnt < 4'(CFH_FRAME_BYTES)) begin
      d.fb[q.bcnt] = can_byte;
      d.bcnt = q.bcnt + 4'h1;
    end
    if (can_frame_end) begin
      d.bcnt = 4'h0;
      // Frames ending mid-scan are dropped; scan is far shorter than a frame
      if (!can_frame_err && q.st == CFH_SCAN_IDLE) begin
        d.sb = q.fb;
        d.ts = q.stime;
        d.msg_done = 1'b1;
        d.obj = '0;
        d.st = CFH_SCAN_CMP;
      end
    end

    // Host side clears of status bits, hardware sets win below
    d.rxs = q.rxs & ~obj_read_ack;
    d.ovr = q.ovr & ~ovr_clr;

    // Acceptance scan, one object after another
    case (q.st)
      CFH_SCAN_IDLE: begin
        d.cnt = 4'h0;
      end
      CFH_SCAN_CMP: begin
        d.cnt = 4'h0;
        d.dlc = (dlc_raw > 4'(CFH_MAX_DATA)) ? 4'(CFH_MAX_DATA) : dlc_raw;
        if ({q.sb[CFH_OFS_ID], q.sb[CFH_OFS_CTRL]} ==
            acc_id[q.obj*16 +: 16]) begin
          if (q.rxs[q.obj] && !obj_read_ack[q.obj]) begin
            d.ovr[q.obj] = 1'b1;
          end
          d.rxs[q.obj] = 1'b1;
          d.mem[base + MW'(CFH_OFS_ID)] = q.sb[CFH_OFS_ID];
          d.mem[base + MW'(CFH_OFS_CTRL)] = q.sb[CFH_OFS_CTRL];
          d.st = CFH_SCAN_COPY;
        end else if (q.obj == OW'(NOBJ - 1)) begin
          d.st = CFH_SCAN_IDLE;
        end else begin
          d.obj = q.obj + OW'(1);
        end
      end
      CFH_SCAN_COPY: begin
        // At most eight data cycles keep one object under 19 cycles
        if (q.cnt < q.dlc) begin
          d.mem[base + MW'(CFH_OFS_DATA) + MW'(q.cnt)] =
            q.sb[4'(CFH_OFS_DATA) + q.cnt];
          d.cnt = q.cnt + 4'h1;
        end else begin
          d.st = CFH_SCAN_STAMP;
        end
      end
      CFH_SCAN_STAMP: begin
        if (TSTAMP) begin
          d.mem[base + MW'(CFH_OFS_TS_HI)] = q.ts[15:8];
          d.mem[base + MW'(CFH_OFS_TS_LO)] = q.ts[7:0];
        end
        if (q.obj == OW'(NOBJ - 1)) begin
          d.st = CFH_SCAN_IDLE;
        end else begin
          d.obj = q.obj + OW'(1);
          d.st = CFH_SCAN_CMP;
        end
      end
      default: begin
        d.st = CFH_SCAN_IDLE;
      end
    endcase

    // Host read port, registered; out of range reads zero
    if (int'(rd_obj) < NOBJ && int'(rd_idx) < STRIDE) begin
      d.rd = q.mem[MW'(int'(rd_obj) * STRIDE + int'(rd_idx))];
    end else begin
      d.rd = 8'h00;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.sel_sy <= 2'h3;
      q.first_pend <= 1'b1;
      q.hs <= CFH_HS_RST;
      q.stime <= CFH_SYSTIME_RST;
    end else begin
      q <= d;
    end
  end
endmodule

// file: common/cfh_pkg.sv
// Purpose: shared constants for the CAN receive object filter and host link
// Assumes: one ref_clk cycle stands for one instruction cycle
// Notes: object layout is id, control, data, optional time stamp
package cfh_pkg;
  // ==========================================================
  // Link packets
  localparam int CFH_BYTE_W = 8;
  localparam int CFH_BITS_PER_PKT = 8;
  localparam logic CFH_HS_RST = 1'b0;
  localparam int CFH_BUF_DEPTH = 2;

  // ==========================================================
  // Timing, in instruction cycles
  localparam int CFH_INSTR_NS = 5;
  localparam int CFH_CLK_NS = 5;
  localparam int CFH_CLK_PER_INSTR =
    (CFH_INSTR_NS + CFH_CLK_NS - 1) / CFH_CLK_NS;
  localparam int CFH_IDLE_BASE_TC = 4096;
  localparam int CFH_IDLE_BASE_CYC = CFH_IDLE_BASE_TC * CFH_CLK_PER_INSTR;
  localparam int CFH_ACCEPT_MAX_TC = 19;
  localparam logic [15:0] CFH_SYSTIME_RST = 16'h0000;

  // ==========================================================
  // Tick source select codes
  localparam logic [1:0] CFH_TICK_IDLE_FIX = 2'h0;
  localparam logic [1:0] CFH_TICK_IDLE_SEL = 2'h1;
  localparam logic [1:0] CFH_TICK_RELOAD = 2'h2;

  // ==========================================================
  // Frame and object layout
  localparam int CFH_OFS_ID = 0;
  localparam int CFH_OFS_CTRL = 1;
  localparam int CFH_OFS_DATA = 2;
  localparam int CFH_MAX_DATA = 8;
  localparam int CFH_FRAME_BYTES = 10;
  localparam int CFH_OBJ_BYTES = 10;
  localparam int CFH_OBJ_BYTES_TS = 12;
  localparam int CFH_OFS_TS_HI = 10;
  localparam int CFH_OFS_TS_LO = 11;
  localparam logic [7:0] CFH_DLC_MASK = 8'h0f;
  localparam int CFH_MAX_OBJ = 8;

  // ==========================================================
  // Acceptance scan states
  typedef enum logic [1:0] {
    CFH_SCAN_IDLE,
    CFH_SCAN_CMP,
    CFH_SCAN_COPY,
    CFH_SCAN_STAMP
  } cfh_scan_e;
endpackage

// file: verilog/cfh_fifo.sv
// Purpose: small valid/ready buffer for link bytes
// Assumes: DEPTH is a power of two
// Notes: in_ready low when full, out_valid low when empty
`timescale 1ns/10ps
module cfh_fifo import cfh_pkg::*; #(
  parameter int W = 9,
  parameter int DEPTH = CFH_BUF_DEPTH
) (
  input logic clk, // Core clock
  input logic rst_b, // Async reset, active low
  input logic [W-1:0] in_data, // Word to store
  input logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  output logic [W-1:0] out_data, // Oldest word
  output logic out_valid, // Buffer not empty
  input logic out_ready // Consumer takes word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } cfh_fifo_s;

  cfh_fifo_s q, d;
  logic full;
  logic empty;

  // ==========================================================
  // Flags from pointers; extra bit tells full from empty
  assign empty = (q.wp == q.rp);
  assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = q.mem[q.rp[AW-1:0]];

  // Next state
  always_comb begin
    d = q;
    if (in_valid && !full) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + (AW+1)'(1);
    end
    if (out_ready && !empty) begin
      d.rp = q.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// file: verilog/cfh_link.sv
// Purpose: serial shift register on the host's shift clock
// Assumes: core holds reply stable until the handshake line inverts
// Notes: each eighth clock latches a byte and flips a toggle
`timescale 1ns/10ps
module cfh_link import cfh_pkg::*; (
  input logic serial_shift_clock, // Link clock from host
  input logic rst_b, // Async reset, active low
  input logic sdi, // Serial data from host
  output logic sdo, // Serial data to host
  input logic [7:0] tx_byte, // Reply byte, held stable
  output logic [7:0] rx_byte, // Last whole byte
  output logic rx_tgl // Flips per whole byte
);
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [7:0] rx;
    logic tgl;
  } cfh_link_s;

  cfh_link_s q, d;

  // ==========================================================
  // Reply MSB first; first bit comes straight from reply byte
  assign sdo = (q.cnt == 3'h0) ? tx_byte[7] : q.sh[7];
  assign rx_byte = q.rx;
  assign rx_tgl = q.tgl;

  // Shift one bit per clock, hand over on the eighth
  always_comb begin
    d = q;
    if (q.cnt == 3'h0) begin
      d.sh = {tx_byte[6:0], sdi};
    end else begin
      d.sh = {q.sh[6:0], sdi};
    end
    d.cnt = q.cnt + 3'h1;
    if (q.cnt == 3'(CFH_BITS_PER_PKT - 1)) begin
      d.rx = d.sh;
      d.tgl = !q.tgl;
    end
  end

  // Clock stands still between bytes, so nothing here needs a timeout
  always_ff @(posedge serial_shift_clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// file: tb/cfh_host_model.sv
// Purpose: host side of the serial link
// Assumes: shift clock idles low, runs only inside a byte
// Notes: 15 ns link period, MSB first
`timescale 1ns/10ps
module cfh_host_model (
  output logic serial_shift_clock, // Link clock
  output logic link_sdi, // Data to block
  output logic link_sel_b, // Select, low
  input wire logic link_sdo, // Data from block
  input wire logic link_hs // Handshake level
);
  // ==================================================
  // Idle levels
  initial begin
    serial_shift_clock = 1'b0;
    link_sdi = 1'b0;
    link_sel_b = 1'b1;
  end

  // High for a while re-arms the command slot
  // Moves off the core clock edges so later samples never race them
  task automatic sel(input bit on);
    #1;
    link_sel_b = !on;
    #21;
  endtask

  // One 8-bit packet each way, then wait for the flip if w is set
  task automatic xfer(input logic [7:0] b, input bit w,
                      output logic [7:0] r, output bit late);
    logic hs0;
    hs0 = link_hs;
    late = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      link_sdi = b[i];
      #7.5;
      r[i] = link_sdo;
      serial_shift_clock = 1'b1;
      #7.5;
      serial_shift_clock = 1'b0;
    end
    // Released line must not keep the last bit
    link_sdi = ~b[0];
    late = w;
    for (int n = 0; n < 100 && late; n++) begin
      #5;
      late = (link_hs === hs0);
    end
  endtask
endmodule

// file: tb/cfh_core_sva.sv
// Purpose: port checks on the receive filter core
// Assumes: one ref_clk domain at the ports
// Notes: scan bound is eleven cycles per object
`timescale 1ns/10ps
module cfh_core_sva #(
  parameter int NOBJ = 8
) (
  input logic ref_clk, // Clock
  input logic rst_b, // Reset, low
  input logic host_byte_valid, // Byte waiting
  input logic host_byte_ready, // Byte taken
  input logic host_byte_cmd, // Command
  input logic link_hs, // Handshake
  input logic link_req_irq, // Byte pulse
  input logic comm_req_flag, // Request
  input logic rx_buffer_full_flag, // CAN byte
  input logic can_tx_done, // Tx end
  input logic can_err_evt, // Bus error
  input logic can_rx_irq, // Rx event
  input logic can_tx_irq, // Tx event
  input logic can_err_irq, // Err event
  input logic can_frame_end, // Frame end
  input logic can_frame_err, // Frame bad
  input logic msg_complete, // Good frame
  input logic scan_busy, // Scanning
  input logic auto_tx_req, // Timed send
  input logic [NOBJ-1:0] rx_overwrite // Overrun
);
  // ==================================================
  // Scan length counter; a hung scan shows up here
  localparam int SCAN_MAX = NOBJ * 11;
  logic [7:0] scan_len_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_len_r <= 8'h00;
    end else begin
      scan_len_r <= scan_busy ? scan_len_r + 8'h01 : 8'h00;
    end
  end

  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // ==================================================
  // Assertions
  hs_flip_a: assert property (
    host_byte_valid && host_byte_ready |=> link_hs != $past(link_hs))
    else $error("handshake did not invert");
  hs_hold_a: assert property (
    !(host_byte_valid && host_byte_ready) |=> $stable(link_hs))
    else $error("handshake moved without a take");
  req_valid_a: assert property (
    link_req_irq |-> host_byte_valid)
    else $error("request pulse without byte");
  cmd_flag_a: assert property (
    link_req_irq && host_byte_cmd |-> ##[0:1] comm_req_flag)
    else $error("command did not set flag");
  rx_irq_a: assert property (
    rx_buffer_full_flag |=> can_rx_irq)
    else $error("missing receive event");
  tx_irq_a: assert property (
    can_tx_irq == $past(can_tx_done))
    else $error("transmit event mismatch");
  err_irq_a: assert property (
    can_err_evt |=> can_err_irq)
    else $error("missing error event");
  good_frame_a: assert property (
    can_frame_end && !can_frame_err && !scan_busy |=> msg_complete)
    else $error("good frame not flagged");
  bad_frame_a: assert property (
    msg_complete |-> $past(can_frame_end) && !$past(can_frame_err))
    else $error("complete flag without good frame");
  scan_len_a: assert property (
    scan_len_r <= SCAN_MAX)
    else $error("filter scan too long");
  ovr_scan_a: assert property (
    $rose(|rx_overwrite) |-> scan_busy)
    else $error("overrun set outside a scan");

  // Main scenarios reached
  good_c: cover property (msg_complete);
  ovr_c: cover property ($rose(|rx_overwrite));
  auto_c: cover property (auto_tx_req);
endmodule

// file: tb/test_cfh_core.sv
// Purpose: self-checking bench for the receive filter core
// Assumes: host model on the link, CAN strobes from the bench
// Notes: short idle base keeps tick runs brief
`timescale 1ns/10ps
module test_cfh_core import cfh_pkg::*; ;
  localparam int NB = 4;
  localparam int IB = 16;
  logic ref_clk = 1'b0, rst_b = 1'b0;
  logic host_byte_ready = 1'b0, comm_req_clr = 1'b0, auto_tx_en = 1'b0;
  logic rx_buffer_full_flag = 1'b0, can_frame_end = 1'b0;
  logic can_frame_err = 1'b0, can_tx_done = 1'b0, can_err_evt = 1'b0;
  logic [7:0] reply_byte = 8'h00, can_byte = 8'h00;
  logic [1:0] tick_src = 2'h0, idle_div_sel = 2'h0;
  logic [15:0] reload_value = 16'h0000;
  logic [NB*16-1:0] acc_id = {16'h3308, 16'h1103, 16'h2200, 16'h1103};
  logic [NB-1:0] obj_read_ack = 4'h0, ovr_clr = 4'h0;
  logic [2:0] rd_obj = 3'h0;
  logic [3:0] rd_idx = 4'h0;
  logic serial_shift_clock, link_sdi, link_sdo, link_sel_b, link_hs;
  logic host_byte_cmd, host_byte_valid, comm_req_flag, link_req_irq;
  logic tick_pulse, auto_tx_req, can_rx_irq, can_tx_irq, can_err_irq;
  logic msg_complete, scan_busy;
  logic [7:0] host_byte, rd_data;
  logic [15:0] sys_time;
  logic [NB-1:0] rx_status, rx_overwrite;
  logic [8:0] got_q[$];
  int bad_count = 0, num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;
  cfh_core #(.NOBJ(NB), .IDLE_BASE(IB)) DUT (.*);
  cfh_host_model host (.*);

  // Bytes the user side took; sampled mid-cycle, clear of the launching edge
  always @(negedge ref_clk) begin
    if (host_byte_valid === 1'b1 && host_byte_ready) begin
      got_q.push_back({host_byte_cmd, host_byte});
    end
  end

  // ==================================================
  // Tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, x, input string s);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, s, g, x);
    end
  endtask

  // Bounded wait: scan end (k=0) or tick (k=1)
  task automatic till(input bit k, output int n);
    logic c;
    n = 0;
    c = 1'b0;
    while (c !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      c = k ? tick_pulse : !scan_busy;
      if (n > 600) begin
        bad_count++;
        $display("ERROR %0t wait ran out", $time);
        wrap_up();
      end
    end
  endtask

  task automatic hx(input logic [7:0] b, input bit w, input logic [7:0] e);
    logic [7:0] r;
    bit late;
    host.xfer(b, w, r, late);
    if (w) begin
      chk({7'h00, late, r}, {8'h00, e}, "reply");
    end
  endtask

  // Whole frame, bytes back to back, data byte at frame offset i holds base+i
  task automatic frame(input logic [7:0] id, ct, bs, input bit err);
    int n;
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      rx_buffer_full_flag <= 1'b1;
      can_byte <= i == 0 ? id : i == 1 ? ct : bs + 8'(i);
    end
    @(posedge ref_clk);
    rx_buffer_full_flag <= 1'b0;
    can_frame_end <= 1'b1;
    can_frame_err <= err;
    @(posedge ref_clk);
    can_frame_end <= 1'b0;
    till(1'b0, n);
  endtask

  task automatic rd(input logic [2:0] o, input logic [3:0] x,
                    input logic [7:0] e);
    @(posedge ref_clk);
    rd_obj <= o;
    rd_idx <= x;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'(rd_data), 16'(e), "object byte");
  endtask

  // ==================================================
  // Main sequence
  initial begin
    int n;
    logic [15:0] t;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host_byte_ready <= 1'b1;
    reply_byte <= 8'h3c;
    host.sel(1'b1);
    hx(8'ha5, 1'b1, 8'h00);
    hx(8'h5a, 1'b1, 8'h3c);
    host.sel(1'b0);
    chk({7'h00, got_q.pop_front()}, 16'h01a5, "cmd");
    chk({7'h00, got_q.pop_front()}, 16'h005a, "data");
    chk(16'(comm_req_flag), 16'h0001, "flag");
    @(posedge ref_clk);
    comm_req_clr <= 1'b1;
    @(posedge ref_clk);
    comm_req_clr <= 1'b0;
    host_byte_ready <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(16'(comm_req_flag), 16'h0000, "req clear");
    // Receiver stalls: two bytes kept, third refused
    host.sel(1'b1);
    for (int i = 0; i < 3; i++) begin
      hx(8'h10 + 8'(i), 1'b0, 8'h00);
    end
    repeat (8) @(posedge ref_clk);
    host_byte_ready <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    host.sel(1'b0);
    chk(16'(got_q.size()), 16'h0002, "depth");
    chk({7'h00, got_q.pop_front()}, 16'h0110, "first");
    chk(16'(host_byte_valid), 16'h0000, "drained");
    $display("test link done");
    // Tick sources: fixed, four rates, reload timer
    for (int m = 0; m < 6; m++) begin
      @(posedge ref_clk);
      auto_tx_en <= 1'b1;
      reload_value <= 16'h0009;
      tick_src <= m == 0 ? CFH_TICK_IDLE_FIX :
        m < 5 ? CFH_TICK_IDLE_SEL : CFH_TICK_RELOAD;
      idle_div_sel <= 2'(m - 1);
      till(1'b1, n);
      till(1'b1, n);
      t = sys_time;
      till(1'b1, n);
      chk(16'(n), m == 0 ? 16'(IB) : m < 5 ? 16'(IB << (m - 1)) :
        16'h000a, "tick gap");
      chk(sys_time, t + 16'h0001, "time");
      chk(16'(auto_tx_req), 16'h0001, "auto tx");
    end
    @(posedge ref_clk);
    reload_value <= 16'hffff;
    can_tx_done <= 1'b1;
    can_err_evt <= 1'b1;
    @(posedge ref_clk);
    can_tx_done <= 1'b0;
    can_err_evt <= 1'b0;
    $display("test tick done");
    t = sys_time;
    frame(8'h11, 8'h03, 8'h40, 1'b0);
    chk(16'(rx_status), 16'h0005, "match");
    rd(3'h2, 4'h4, 8'h44);
    rd(3'h0, 4'ha, t[15:8]);
    rd(3'h0, 4'hb, t[7:0]);
    frame(8'h11, 8'h03, 8'h50, 1'b1);
    rd(3'h0, 4'h2, 8'h42);
    frame(8'h11, 8'h03, 8'h50, 1'b0);
    chk(16'(rx_overwrite), 16'h0005, "overrun");
    rd(3'h0, 4'h3, 8'h53);
    @(posedge ref_clk);
    obj_read_ack <= 4'h1;
    ovr_clr <= 4'h5;
    @(posedge ref_clk);
    obj_read_ack <= 4'h0;
    ovr_clr <= 4'h0;
    frame(8'h22, 8'h00, 8'h60, 1'b0);
    chk(16'(rx_status), 16'h0006, "dlc zero");
    rd(3'h1, 4'h2, 8'h00);
    chk(16'(rx_overwrite), 16'h0000, "cleared");
    frame(8'h33, 8'h05, 8'h70, 1'b0);
    chk(16'(rx_status), 16'h0006, "no match");
    $display("test filter done");
    wrap_up();
  end
endmodule

bind cfh_core cfh_core_sva #(.NOBJ(NOBJ)) chk_i (.*);
